// *** rtl/irq_cmd_regs.svh ***
// register offsets, field positions and reset values of the command block
`ifndef IRQ_CMD_REGS_SVH
`define IRQ_CMD_REGS_SVH
`define OFS_SRC_MODE_BASE 12'h000
`define OFS_SRC_VECTOR_BASE 12'h080
`define OFS_NORMAL_VECTOR 12'h100
`define OFS_FAST_VECTOR 12'h104
`define OFS_CURRENT_ID 12'h108
`define OFS_PENDING 12'h10C
`define OFS_ENABLE_MASK 12'h110
`define OFS_CORE_LINE_STATUS 12'h114
`define OFS_ENABLE_CMD 12'h120
`define OFS_DISABLE_CMD 12'h124
`define OFS_PEND_CLEAR_CMD 12'h128
`define OFS_PEND_SET_CMD 12'h12C
`define OFS_END_OF_SERVICE 12'h130
`define OFS_SPURIOUS_VECTOR 12'h134
`define OFS_DEBUG_CONTROL 12'h138
`define OFS_FAST_ROUTE_EN 12'h140
`define OFS_FAST_ROUTE_DIS 12'h144
`define OFS_FAST_ROUTE_STATUS 12'h148
`define BIT_FAST_LINE_STATUS 0
`define BIT_NORMAL_LINE_STATUS 1
`define BIT_PROTECTION_MODE 0
`define BIT_GLOBAL_MASK 1
`define BIT_FAST_SOURCE 0
`define RST_WORD 32'h0000_0000
`define FAST_ROUTE_VALID 32'hFFFF_FFFE
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** rtl/irq_cmd_pkg.sv ***
// types shared by the command block
package irq_cmd_pkg;
    typedef struct packed {
        logic [31:0] src;
    } src_vec_t;
    typedef struct packed {
        logic valid;
        logic [11:0] addr;
        logic [31:0] data;
    } reg_wr_t;
    typedef enum logic [1:0] {
        RD_IDLE,
        RD_RESP
    } rd_state_t;
endpackage : irq_cmd_pkg

// *** rtl/set_clear_bits.sv ***
// bit vector with independent set and clear strobes, set wins
`timescale 1ns/1ps
module set_clear_bits #(
    parameter int WIDTH = 32,
    parameter logic [WIDTH-1:0] VALID = '1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // strobes
    input wire logic [WIDTH-1:0] set_bits,
    input wire logic [WIDTH-1:0] clr_bits,
    // state
    output logic [WIDTH-1:0] q
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= ((q & ~clr_bits) | set_bits) & VALID;
        end
    end
endmodule : set_clear_bits

// *** rtl/sync2.sv ***
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module sync2 #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // levels
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : sync2

// *** rtl/irq_cmd_regs.sv ***
// command, status and routing part of the vectored interrupt controller
`timescale 1ns/1ps
`include "irq_cmd_regs.svh"
module irq_cmd_regs
    import irq_cmd_pkg::*;
#(
    parameter int NSRC = 32
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupt source levels, active high
    input wire logic [NSRC-1:0] source_level,
    // processor lines, active low
    output logic fast_request_line_n,
    output logic normal_request_line_n,
    // protection mode bit to debug logic
    output logic protection_mode_bit
);
    logic [11:0] aw_addr_r;
    logic aw_full_r;
    logic [31:0] w_data_r;
    logic w_full_r;
    reg_wr_t wr;
    src_vec_t mask_q;
    src_vec_t pend_q;
    src_vec_t route_q;
    src_vec_t level_s;
    logic [NSRC-1:0] mask_set, mask_clr, pend_set, pend_clr;
    logic [NSRC-1:0] route_set, route_clr;
    logic [NSRC-1:0] level_d_r;
    logic [31:0] spurious_r;
    logic [1:0] debug_r;
    logic [31:0] vector_r [NSRC];
    logic [4:0] current_r;
    logic current_valid_r;
    logic [4:0] cand_id;
    logic cand_valid;
    logic [NSRC-1:0] normal_req;
    logic fast_req;
    logic ack_rd;
    logic ack_wr;
    logic eos_wr;
    rd_state_t rd_state_r;
    logic [31:0] rd_data;
    logic rd_hit;

    // write address and data may come in either order
    // byte strobes are ignored: every register takes a whole word
    assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
    assign s_axi_wready = !w_full_r && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            aw_addr_r <= 12'h000;
        end else if (wr.valid) begin
            aw_full_r <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_r <= 1'b0;
            w_data_r <= `RST_WORD;
        end else if (wr.valid) begin
            w_full_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_r <= 1'b1;
            w_data_r <= s_axi_wdata;
        end
    end
    always_comb begin
        wr.valid = aw_full_r && w_full_r;
        wr.addr = {aw_addr_r[11:2], 2'b00};
        wr.data = w_data_r;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (wr.valid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // command strobes
    always_comb begin
        mask_set = '0;
        mask_clr = '0;
        pend_set = '0;
        pend_clr = '0;
        route_set = '0;
        route_clr = '0;
        eos_wr = 1'b0;
        ack_wr = 1'b0;
        if (wr.valid) begin
            unique case (wr.addr)
                `OFS_ENABLE_CMD: mask_set = wr.data;
                `OFS_DISABLE_CMD: mask_clr = wr.data;
                `OFS_PEND_CLEAR_CMD: pend_clr = wr.data;
                `OFS_PEND_SET_CMD: pend_set = wr.data;
                `OFS_END_OF_SERVICE: eos_wr = 1'b1;
                `OFS_FAST_ROUTE_EN: route_set = wr.data;
                `OFS_FAST_ROUTE_DIS: route_clr = wr.data;
                `OFS_NORMAL_VECTOR: ack_wr = debug_r[`BIT_PROTECTION_MODE];
                default: ;
            endcase
        end
        // edge sources latch on a rising level
        pend_set = pend_set | (level_s.src & ~level_d_r);
        // acknowledge clears the source that becomes current; current_r
        // still names the previous one in this cycle
        if ((ack_rd || ack_wr) && cand_valid) begin
            pend_clr[cand_id] = 1'b1;
        end
        // enable wins when both strobes reach the mask
        if (mask_set != '0 && mask_clr != '0) begin
            mask_clr = '0;
        end
    end

    sync2 #(.WIDTH(NSRC)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(source_level),
        .q(level_s)
    );
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_d_r <= '0;
        end else begin
            level_d_r <= level_s.src;
        end
    end

    set_clear_bits #(.WIDTH(NSRC)) u_mask (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_bits(mask_set),
        .clr_bits(mask_clr),
        .q(mask_q)
    );
    set_clear_bits #(.WIDTH(NSRC)) u_pend (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_bits(pend_set),
        .clr_bits(pend_clr),
        .q(pend_q)
    );
    set_clear_bits #(.WIDTH(NSRC), .VALID(`FAST_ROUTE_VALID)) u_route (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_bits(route_set),
        .clr_bits(route_clr),
        .q(route_q)
    );

    // software registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            spurious_r <= `RST_WORD;
        end else if (wr.valid && wr.addr == `OFS_SPURIOUS_VECTOR) begin
            spurious_r <= wr.data;
        end
    end
    // only the two defined debug bits are stored, the rest read as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            debug_r <= 2'b00;
        end else if (wr.valid && wr.addr == `OFS_DEBUG_CONTROL) begin
            debug_r <= wr.data[1:0];
        end
    end
    // handler addresses, one word per source
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NSRC; i++) begin
                vector_r[i] <= `RST_WORD;
            end
        end else if (wr.valid && wr.addr[11:7] == 5'h01) begin
            vector_r[wr.addr[6:2]] <= wr.data;
        end
    end
    assign protection_mode_bit = debug_r[`BIT_PROTECTION_MODE];

    // lowest numbered enabled pending normal source wins
    // scanning downwards leaves the lowest index as the last assignment
    assign normal_req = pend_q.src & mask_q.src & ~route_q.src
        & ~(32'h1);
    always_comb begin
        cand_valid = 1'b0;
        cand_id = 5'h00;
        for (int i = NSRC - 1; i > 0; i--) begin
            if (normal_req[i]) begin
                cand_valid = 1'b1;
                cand_id = 5'(i);
            end
        end
    end
    // forced sources bypass priority onto the fast line
    assign fast_req = |(pend_q.src & mask_q.src
        & (route_q.src | 32'h1));

    // current interrupt, latched on acknowledge, released by end-of-service
    // end-of-service takes precedence over an acknowledge in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            current_valid_r <= 1'b0;
            current_r <= 5'h00;
        end else if (eos_wr) begin
            current_valid_r <= 1'b0;
        end else if ((ack_rd || ack_wr) && cand_valid) begin
            current_valid_r <= 1'b1;
            current_r <= cand_id;
        end
    end

    // request lines, active low, held inactive by the global mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_request_line_n <= 1'b1;
        end else begin
            fast_request_line_n <= !(fast_req
                && !debug_r[`BIT_GLOBAL_MASK]);
        end
    end
    // normal line waits while an interrupt is being served
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            normal_request_line_n <= 1'b1;
        end else begin
            normal_request_line_n <= !(cand_valid && !current_valid_r
                && !debug_r[`BIT_GLOBAL_MASK]);
        end
    end

    // read path
    assign s_axi_arready = (rd_state_r == RD_IDLE);
    assign ack_rd = s_axi_arvalid && s_axi_arready
        && {s_axi_araddr[11:2], 2'b00} == `OFS_NORMAL_VECTOR
        && !debug_r[`BIT_PROTECTION_MODE];
    always_comb begin
        rd_data = `RST_WORD;
        rd_hit = 1'b1;
        unique case ({s_axi_araddr[11:2], 2'b00})
            `OFS_NORMAL_VECTOR: rd_data = cand_valid ? vector_r[cand_id]
                : spurious_r;
            `OFS_FAST_VECTOR: rd_data = fast_req ? vector_r[0]
                : spurious_r;
            `OFS_CURRENT_ID: rd_data = {27'h0, current_r};
            `OFS_PENDING: rd_data = pend_q.src;
            `OFS_ENABLE_MASK: rd_data = mask_q.src;
            `OFS_CORE_LINE_STATUS: rd_data = {30'h0,
                !normal_request_line_n, !fast_request_line_n};
            `OFS_SPURIOUS_VECTOR: rd_data = spurious_r;
            `OFS_DEBUG_CONTROL: rd_data = {30'h0, debug_r};
            `OFS_FAST_ROUTE_STATUS: rd_data = route_q.src;
            default: begin
                // source vector words, anything else is unmapped
                if (s_axi_araddr[11:7] == 5'h01) begin
                    rd_data = vector_r[s_axi_araddr[6:2]];
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_r <= RD_IDLE;
        end else begin
            unique case (rd_state_r)
                RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rd_state_r <= RD_RESP;
                    end
                end
                RD_RESP: begin
                    if (s_axi_rready) begin
                        rd_state_r <= RD_IDLE;
                    end
                end
                default: rd_state_r <= RD_IDLE;
            endcase
        end
    end
    // read data is captured with the address and stands until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= `RST_WORD;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
    end
    assign s_axi_rvalid = (rd_state_r == RD_RESP);
endmodule : irq_cmd_regs

// *** test/irq_cmd_monitor.sv ***
// concurrent checks on the bus and request lines of the command block
`timescale 1ns/1ps
module irq_cmd_monitor (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // lines
    input wire logic fast_request_line_n,
    input wire logic normal_request_line_n,
    input wire logic protection_mode_bit
);
    logic ar_go;
    assign ar_go = s_axi_arvalid && s_axi_arready;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("write response dropped");
    a_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
        else $error("write response not okay");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
    a_read_answer: assert property (ar_go |=> s_axi_rvalid)
        else $error("read not answered");
    a_write_busy: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write taken early");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken early");
    a_unmapped_err: assert property (ar_go && s_axi_araddr == 12'h118 |=>
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_line_status: assert property (
        ar_go && s_axi_araddr == 12'h114 && $stable(fast_request_line_n)
        && $stable(normal_request_line_n) ##1 $stable(fast_request_line_n)
        && $stable(normal_request_line_n) |-> s_axi_rdata[1:0] ==
        ~{normal_request_line_n, fast_request_line_n})
        else $error("line status mismatch");
    a_protection_mode_bit_write: assert property (
        $changed(protection_mode_bit) |-> $rose(s_axi_bvalid))
        else $error("protection bit moved without write");
endmodule : irq_cmd_monitor

bind irq_cmd_regs irq_cmd_monitor i_mon (.aclk, .aresetn, .s_axi_awready,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fast_request_line_n,
    .normal_request_line_n, .protection_mode_bit);

// *** test/core_model.sv ***
// behavioural core that samples the two active-low request lines
`timescale 1ns/1ps
module core_model (
    // clock
    input wire logic aclk,
    // request lines
    input wire logic fast_request_line_n,
    input wire logic normal_request_line_n,
    // sampled activity
    output logic fast_act,
    output logic normal_act
);
    always_ff @(posedge aclk) begin
        fast_act <= !fast_request_line_n;
        normal_act <= !normal_request_line_n;
    end
endmodule : core_model

// *** test/irq_cmd_regs_tb_top.sv ***
// directed testbench of the command block
`timescale 1ns/1ps
module irq_cmd_regs_tb_top;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, source_level;
    logic [3:0] s_axi_wstrb;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, fast_request_line_n, normal_request_line_n;
    wire protection_mode_bit, fast_act, normal_act;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    int errors, n_checks;

    irq_cmd_regs i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .source_level,
        .fast_request_line_n, .normal_request_line_n, .protection_mode_bit);
    core_model i_core (.aclk, .fast_request_line_n, .normal_request_line_n,
        .fast_act, .normal_act);

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic give_verdict;
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            if (tb) chk(32'(s_axi_bresp), 32'h0);
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) begin
                s_axi_bready <= 1'b0;
                return;
            end
        end
        errors++;
        give_verdict();
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic ta, tb;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tb = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tb) begin
                s_axi_rready <= 1'b0;
                return;
            end
        end
        errors++;
        give_verdict();
    endtask : rd

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, e);
        chk(32'(r), 32'h0);
    endtask : rchk

    // lines settle one cycle after the state, the core samples one later
    task automatic ln(input logic [1:0] e);
        repeat (3) @(posedge aclk);
        chk({30'h0, normal_act, fast_act}, {30'h0, e});
    endtask : ln

    task automatic t_reset;
        logic [11:0] ra [6] = '{12'h110, 12'h114, 12'h134, 12'h138,
                                12'h148, 12'h10C};
        logic [31:0] d;
        logic [1:0] r;
        foreach (ra[i]) rchk(ra[i], 32'h0);
        rd(12'h118, d, r);
        chk({d[29:0], r}, 32'h2);
        wr(12'h118, 32'hFFFF_FFFF);
        ln(2'b00);
    endtask : t_reset

    task automatic t_mask;
        wr(12'h120, 32'h8000_0007);
        rchk(12'h110, 32'h8000_0007);
        wr(12'h124, 32'h0000_0002);
        wr(12'h124, 32'h0);
        wr(12'h120, 32'h0);
        rchk(12'h110, 32'h8000_0005);
        wr(12'h124, 32'hFFFF_FFFF);
        rchk(12'h110, 32'h0);
    endtask : t_mask

    task automatic t_pend;
        wr(12'h12C, 32'h8000_0008);
        rchk(12'h10C, 32'h8000_0008);
        wr(12'h128, 32'h0000_0008);
        wr(12'h128, 32'h0);
        rchk(12'h10C, 32'h8000_0000);
        wr(12'h128, 32'h8000_0000);
        source_level <= 32'h0000_0020;
        repeat (6) @(posedge aclk);
        source_level <= 32'h0;
        rchk(12'h10C, 32'h0000_0020);
        wr(12'h128, 32'h0000_0020);
        rchk(12'h10C, 32'h0);
        ln(2'b00);
    endtask : t_pend

    task automatic t_vec;
        wr(12'h134, 32'hCAFE_0004);
        rchk(12'h134, 32'hCAFE_0004);
        rchk(12'h100, 32'hCAFE_0004);
        rchk(12'h104, 32'hCAFE_0004);
        wr(12'h090, 32'h0000_4440);
        wr(12'h120, 32'h0000_0010);
        wr(12'h12C, 32'h0000_0010);
        ln(2'b10);
        rchk(12'h114, 32'h2);
        rchk(12'h100, 32'h0000_4440);
        rchk(12'h108, 32'h4);
        rchk(12'h10C, 32'h0);
        ln(2'b00);
        wr(12'h130, 32'hDEAD_BEEF);
        rchk(12'h100, 32'hCAFE_0004);
    endtask : t_vec

    task automatic t_fast;
        wr(12'h140, 32'hFFFF_FFFF);
        rchk(12'h148, 32'hFFFF_FFFE);
        wr(12'h144, 32'h0000_FFFF);
        rchk(12'h148, 32'hFFFF_0000);
        wr(12'h080, 32'h0000_0880);
        wr(12'h120, 32'h0001_0000);
        wr(12'h12C, 32'h0001_0000);
        ln(2'b01);
        rchk(12'h114, 32'h1);
        rchk(12'h104, 32'h0000_0880);
        wr(12'h128, 32'h0001_0000);
        ln(2'b00);
        wr(12'h144, 32'hFFFF_FFFF);
        wr(12'h124, 32'h0001_0000);
        rchk(12'h148, 32'h0);
    endtask : t_fast

    task automatic t_debug;
        logic [31:0] d;
        logic [1:0] r;
        wr(12'h138, 32'h3);
        rchk(12'h138, 32'h3);
        chk({31'h0, protection_mode_bit}, 32'h1);
        wr(12'h12C, 32'h0000_0010);
        ln(2'b00);
        rd(12'h100, d, r);
        chk(d, 32'h0000_4440);
        rchk(12'h10C, 32'h0000_0010);
        wr(12'h100, 32'h0);
        rchk(12'h10C, 32'h0);
        wr(12'h130, 32'h0);
        wr(12'h138, 32'h0);
        rchk(12'h138, 32'h0);
        chk({31'h0, protection_mode_bit}, 32'h0);
    endtask : t_debug

    initial begin
        errors = 0;
        n_checks = 0;
        aresetn = 1'b0;
        s_axi_awaddr = 12'h0;
        s_axi_araddr = 12'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        source_level = 32'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_mask();
        t_pend();
        t_vec();
        t_fast();
        t_debug();
        give_verdict();
    end
endmodule : irq_cmd_regs_tb_top
